/* logic/tpfm_pin_mux.v */
// Purpose: pin function selection and default states of the digital pins
// Assumes: one 20 MHz clock; configuration bits arrive as plain ports
// Notes:   every pin three-stated in reset and after sync loss
`timescale 1ns/1ps
`default_nettype none
`include "tpfm_regs.vh"

// How it works
// - sample both straps after reset release, once synchronised
// - strap b high-z until configured as gpio
// - strap b may output an auxiliary clock
// - bit clock input in main, output otherwise
// - subordinate bit clock may drive mic clock
// - frame sync input in main, output otherwise
// - stalled frame sync resets bus after delay
// - frame sync marks serial frame boundaries
// - tx pin a drives serial data when enabled
// - tx pin a gpio otherwise, high-z first
// - sync loss or brownout returns pins high-z
// - tx pin b can take second receive
// - tx pin b gpio only when both off
// - rx pin a mic, serial, else gpio
// - no-serial variant: tx pins gpio only
// - no-serial variant: rx a mic or gpio
// - all pins three-stated during reset
// - main mic clock is 64x frame sync
module tpfm_pin_mux
#(
    parameter        HAS_SERIAL   = 1,
    parameter [31:0] SYNC_LOSS_CYC = `TPFM_SYNC_LOSS_CYC
)
(
    input  wire                       CLK,
    input  wire                       ARST_N,
    input  wire                       LOW_SUPPLY,
    input  wire                       MAIN_ROLE,
    input  wire                       ADDR_STRAP_PIN_A_I,
    input  wire                       ADDR_STRAP_PIN_B_I,
    output reg                        ADDR_STRAP_PIN_B_O,
    output reg                        ADDR_STRAP_PIN_B_OE,
    input  wire                       AUX_CLOCK_OUT_B_EN,
    input  wire [`TPFM_AUXDIV_W-1:0]  AUX_CLOCK_DIV,
    input  wire                       BCLK_PIN_I,
    output reg                        BCLK_PIN_O,
    output reg                        BCLK_PIN_OE,
    input  wire                       BCLK_OUT_VAL,
    input  wire                       BCLK_AS_MIC_CLOCK,
    input  wire                       FSYNC_PIN_I,
    output reg                        FSYNC_PIN_O,
    output reg                        FSYNC_PIN_OE,
    input  wire                       FSYNC_OUT_VAL,
    output reg                        MIC_CLOCK_OUT,
    output reg                        FRAME_START,
    output reg                        SYNC_LOST,
    output reg  [6:0]                 I2C_TARGET_ADDR,
    input  wire                       TX_FUNC_A_EN,
    input  wire                       TX_FUNC_A_DATA,
    input  wire                       TX_FUNC_B_EN,
    input  wire                       TX_FUNC_B_DATA,
    input  wire                       RX_FUNC_B_ALT_EN,
    input  wire                       RX_FUNC_A_EN,
    input  wire                       MIC_INPUT_A_EN,
    input  wire                       SERIAL_TX_PIN_A_I,
    output reg                        SERIAL_TX_PIN_A_O,
    output reg                        SERIAL_TX_PIN_A_OE,
    input  wire                       SERIAL_TX_PIN_B_I,
    output reg                        SERIAL_TX_PIN_B_O,
    output reg                        SERIAL_TX_PIN_B_OE,
    input  wire                       SERIAL_RX_PIN_A_I,
    input  wire                       SERIAL_RX_PIN_B_I,
    output reg                        SERIAL_RX_PIN_B_O,
    output reg                        SERIAL_RX_PIN_B_OE,
    output reg                        SERIAL_RX_PIN_A_O,
    output reg                        SERIAL_RX_PIN_A_OE,
    output reg                        RX_FUNC_A_DATA,
    output reg                        RX_FUNC_B_DATA,
    output reg                        MIC_INPUT_A_DATA,
    input  wire [`TPFM_NGPIO-1:0]     GPIO_CFG_EN,
    input  wire [`TPFM_NGPIO-1:0]     GPIO_DIR_OUT,
    input  wire [`TPFM_NGPIO-1:0]     GPIO_OUT_VAL,
    output reg  [`TPFM_NGPIO-1:0]     GPIO_IN_VAL
);
    localparam [1:0] ST_RESET = `TPFM_ST_RESET;
    localparam [1:0] ST_STRAP = `TPFM_ST_STRAP;
    localparam [1:0] ST_RUN   = `TPFM_ST_RUN;
    localparam [2:0] SETTLE   = `TPFM_STRAP_SETTLE;
    localparam [6:0] MIC_LAST = `TPFM_MIC_MULT * 2 - 1;
    localparam [6:0] ADDR_BASE = `TPFM_ADDR_BASE;
    localparam       SERIAL_OK = (HAS_SERIAL != 0);

    // every pin enters through the three-stage synchroniser
    wire s_strap_a;
    wire s_strap_b;
    wire s_bclk;
    wire s_fsync;
    wire s_tx_a;
    wire s_tx_b;
    wire s_rx_a;
    wire s_rx_b;
    wire s_low;
    wire [7:0] raw_in;
    wire [7:0] syn_in;
    assign raw_in = {SERIAL_RX_PIN_B_I, SERIAL_RX_PIN_A_I, SERIAL_TX_PIN_B_I,
                     SERIAL_TX_PIN_A_I, FSYNC_PIN_I, BCLK_PIN_I,
                     ADDR_STRAP_PIN_B_I, ADDR_STRAP_PIN_A_I};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_sync
            tpfm_sync3 u_sync
            (
                .clk    (CLK),
                .arst_n (ARST_N),
                .d      (raw_in[gi]),
                .q      (syn_in[gi])
            );
        end
    endgenerate
    tpfm_sync3 u_sync_low
    (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      (LOW_SUPPLY),
        .q      (s_low)
    );
    assign s_strap_a = syn_in[0];
    assign s_strap_b = syn_in[1];
    assign s_bclk    = syn_in[2];
    assign s_fsync   = syn_in[3];
    assign s_tx_a    = syn_in[4];
    assign s_tx_b    = syn_in[5];
    assign s_rx_a    = syn_in[6];
    assign s_rx_b    = syn_in[7];

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [2:0]  settle_reg;
    reg  [31:0] stall_reg;
    reg         fsync_d_reg;
    reg  [6:0]  mic_cnt_reg;
    reg  [4:0]  mic_div_reg;
    reg         mic_clk_reg;
    reg  [`TPFM_AUXDIV_W-1:0] aux_cnt_reg;
    reg         aux_clk_reg;
    reg  [15:0] fs_period_reg;
    reg  [15:0] fs_cnt_reg;

    wire run      = (state_reg == ST_RUN);
    wire fs_edge  = s_fsync & ~fsync_d_reg;
    wire stalled  = MAIN_ROLE && (stall_reg >= SYNC_LOSS_CYC - 32'h1);

    // chip-level reset cause: stalled frame sync or brownout
    wire chip_rst = stalled | s_low;

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = ST_STRAP;
            ST_STRAP: if (settle_reg == SETTLE) state_next = ST_RUN;
            ST_RUN:   if (chip_rst) state_next = ST_RESET;
            default:  state_next = ST_RESET;
        endcase
    end

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_reg       <= ST_RESET;
            settle_reg      <= 3'h0;
            I2C_TARGET_ADDR <= ADDR_BASE;
        end
        else
        begin
            state_reg  <= state_next;
            settle_reg <= (state_reg == ST_STRAP) ? settle_reg + 3'h1 : 3'h0;
            // straps caught after release, once synchronised
            if (state_reg == ST_STRAP && settle_reg == SETTLE)
                I2C_TARGET_ADDR <= {ADDR_BASE[6:2], s_strap_b, s_strap_a};
        end
    end

    // frame sync watchdog; host must keep it toggling in main role
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            fsync_d_reg <= 1'b0;
            stall_reg   <= 32'h0;
            SYNC_LOST   <= 1'b0;
            FRAME_START <= 1'b0;
        end
        else
        begin
            fsync_d_reg <= s_fsync;
            if (!MAIN_ROLE || fs_edge || !run)
                stall_reg <= 32'h0;
            else if (!stalled)
                stall_reg <= stall_reg + 32'h1;
            SYNC_LOST   <= stalled;
            FRAME_START <= run & fs_edge & SERIAL_OK;
        end
    end

    // mic clock: measure frame period, toggle 2*64-1 times per frame
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            fs_cnt_reg    <= 16'h0;
            fs_period_reg <= 16'h0;
            mic_cnt_reg   <= 7'h0;
            mic_div_reg   <= 5'h0;
            mic_clk_reg   <= 1'b0;
        end
        else if (fs_edge)
        begin
            // realign each frame so rate tracks frame sync, not bit clock
            fs_period_reg <= fs_cnt_reg;
            fs_cnt_reg    <= 16'h0;
            mic_cnt_reg   <= 7'h0;
            mic_div_reg   <= 5'h0;
            mic_clk_reg   <= 1'b0;
        end
        else
        begin
            fs_cnt_reg <= (fs_cnt_reg == 16'hffff) ? fs_cnt_reg
                                                   : fs_cnt_reg + 16'h1;
            if (mic_div_reg >= fs_period_reg[11:7])
            begin
                mic_div_reg <= 5'h0;
                // odd toggle count: 64 rising edges, low again at frame edge
                if (mic_cnt_reg < MIC_LAST)
                begin
                    mic_cnt_reg <= mic_cnt_reg + 7'h1;
                    mic_clk_reg <= ~mic_clk_reg;
                end
            end
            else
                mic_div_reg <= mic_div_reg + 5'h1;
        end
    end

    // auxiliary clock for converters or regulators
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            aux_cnt_reg <= {`TPFM_AUXDIV_W{1'b0}};
            aux_clk_reg <= 1'b0;
        end
        else if (!AUX_CLOCK_OUT_B_EN)
        begin
            aux_cnt_reg <= {`TPFM_AUXDIV_W{1'b0}};
            aux_clk_reg <= 1'b0;
        end
        else if (aux_cnt_reg >= AUX_CLOCK_DIV)
        begin
            aux_cnt_reg <= {`TPFM_AUXDIV_W{1'b0}};
            aux_clk_reg <= ~aux_clk_reg;
        end
        else
            aux_cnt_reg <= aux_cnt_reg + 1'b1;
    end

    // function selects, audio ahead of gpio
    wire tx_a_on  = SERIAL_OK & TX_FUNC_A_EN;
    wire tx_b_on  = SERIAL_OK & TX_FUNC_B_EN;
    wire rxb_alt  = SERIAL_OK & RX_FUNC_B_ALT_EN & ~tx_b_on;
    wire mic_a_on = MIC_INPUT_A_EN;
    wire rx_a_on  = SERIAL_OK & RX_FUNC_A_EN & ~mic_a_on;
    wire rx_b_on  = SERIAL_OK & ~rxb_alt;
    wire [`TPFM_NGPIO-1:0] func_busy;
    assign func_busy = {rx_b_on,
                        rx_a_on | mic_a_on,
                        tx_b_on | rxb_alt,
                        tx_a_on,
                        AUX_CLOCK_OUT_B_EN};
    wire [`TPFM_NGPIO-1:0] g_drive = GPIO_CFG_EN & GPIO_DIR_OUT & ~func_busy;
    wire [`TPFM_NGPIO-1:0] g_pin   = {s_rx_b, s_rx_a, s_tx_b, s_tx_a,
                                      s_strap_b};

    // outputs; anything outside run is three-stated
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ADDR_STRAP_PIN_B_O  <= 1'b0;
            ADDR_STRAP_PIN_B_OE <= 1'b0;
            BCLK_PIN_O          <= 1'b0;
            BCLK_PIN_OE         <= 1'b0;
            FSYNC_PIN_O         <= 1'b0;
            FSYNC_PIN_OE        <= 1'b0;
            MIC_CLOCK_OUT       <= 1'b0;
            SERIAL_TX_PIN_A_O   <= 1'b0;
            SERIAL_TX_PIN_A_OE  <= 1'b0;
            SERIAL_TX_PIN_B_O   <= 1'b0;
            SERIAL_TX_PIN_B_OE  <= 1'b0;
            SERIAL_RX_PIN_A_O   <= 1'b0;
            SERIAL_RX_PIN_A_OE  <= 1'b0;
            SERIAL_RX_PIN_B_O   <= 1'b0;
            SERIAL_RX_PIN_B_OE  <= 1'b0;
            RX_FUNC_A_DATA      <= 1'b0;
            RX_FUNC_B_DATA      <= 1'b0;
            MIC_INPUT_A_DATA    <= 1'b0;
            GPIO_IN_VAL         <= {`TPFM_NGPIO{1'b0}};
        end
        else if (!run || chip_rst)
        begin
            // input buffers off too: captured data held low
            ADDR_STRAP_PIN_B_OE <= 1'b0;
            BCLK_PIN_OE         <= 1'b0;
            FSYNC_PIN_OE        <= 1'b0;
            SERIAL_TX_PIN_A_OE  <= 1'b0;
            SERIAL_TX_PIN_B_OE  <= 1'b0;
            SERIAL_RX_PIN_A_OE  <= 1'b0;
            SERIAL_RX_PIN_B_OE  <= 1'b0;
            MIC_CLOCK_OUT       <= 1'b0;
            RX_FUNC_A_DATA      <= 1'b0;
            RX_FUNC_B_DATA      <= 1'b0;
            MIC_INPUT_A_DATA    <= 1'b0;
            GPIO_IN_VAL         <= {`TPFM_NGPIO{1'b0}};
        end
        else
        begin
            ADDR_STRAP_PIN_B_OE <= AUX_CLOCK_OUT_B_EN | g_drive[`TPFM_G_STRAP_B];
            ADDR_STRAP_PIN_B_O  <= AUX_CLOCK_OUT_B_EN ? aux_clk_reg
                                 : GPIO_OUT_VAL[`TPFM_G_STRAP_B];
            BCLK_PIN_OE  <= ~MAIN_ROLE;
            BCLK_PIN_O   <= BCLK_AS_MIC_CLOCK ? mic_clk_reg
                                              : BCLK_OUT_VAL;
            FSYNC_PIN_OE <= ~MAIN_ROLE;
            FSYNC_PIN_O  <= FSYNC_OUT_VAL;
            MIC_CLOCK_OUT <= mic_clk_reg;
            SERIAL_TX_PIN_A_OE <= tx_a_on | g_drive[`TPFM_G_TX_A];
            SERIAL_TX_PIN_A_O  <= tx_a_on ? TX_FUNC_A_DATA
                                : GPIO_OUT_VAL[`TPFM_G_TX_A];
            SERIAL_TX_PIN_B_OE <= tx_b_on | g_drive[`TPFM_G_TX_B];
            SERIAL_TX_PIN_B_O  <= tx_b_on ? TX_FUNC_B_DATA
                                : GPIO_OUT_VAL[`TPFM_G_TX_B];
            SERIAL_RX_PIN_A_OE <= g_drive[`TPFM_G_RX_A];
            SERIAL_RX_PIN_A_O  <= GPIO_OUT_VAL[`TPFM_G_RX_A];
            SERIAL_RX_PIN_B_OE <= g_drive[`TPFM_G_RX_B] & ~rx_b_on;
            SERIAL_RX_PIN_B_O  <= GPIO_OUT_VAL[`TPFM_G_RX_B];
            RX_FUNC_A_DATA     <= rx_a_on & s_rx_a;
            RX_FUNC_B_DATA     <= rxb_alt ? s_tx_b : (rx_b_on & s_rx_b);
            MIC_INPUT_A_DATA   <= mic_a_on & s_rx_a;
            GPIO_IN_VAL        <= GPIO_CFG_EN & ~func_busy & g_pin;
        end
    end
endmodule // tpfm_pin_mux
`default_nettype wire

/* logic/tpfm_regs.vh */
// Purpose: constants for the transceiver pin function mux
// Assumes: 20 MHz core clock
// Notes:   sync-loss delay is a plain default, shorten in simulation
`ifndef TPFM_REGS_VH
`define TPFM_REGS_VH
`define TPFM_CLK_HZ          20000000
`define TPFM_SYNC_LOSS_US    1000
`define TPFM_SYNC_LOSS_CYC   ((`TPFM_SYNC_LOSS_US * (`TPFM_CLK_HZ / 1000000)))
`define TPFM_MIC_MULT        64
`define TPFM_STRAP_SETTLE    4
`define TPFM_ADDR_BASE       7'h68
`define TPFM_AUXDIV_W        8
// gpio field positions in the gpio bundles
`define TPFM_G_STRAP_B       0
`define TPFM_G_TX_A          1
`define TPFM_G_TX_B          2
`define TPFM_G_RX_A          3
`define TPFM_G_RX_B          4
`define TPFM_NGPIO           5
// pin state machine
`define TPFM_ST_RESET        2'h0
`define TPFM_ST_STRAP        2'h1
`define TPFM_ST_RUN          2'h2
`endif

/* logic/tpfm_sync3.v */
// Purpose: three-stage synchroniser with agree-to-change filter
// Assumes: input is asynchronous to CLK
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module tpfm_sync3
(
    input  wire  clk,
    input  wire  arst_n,
    input  wire  d,
    output reg   q
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q      <= 1'b0;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // a change counts once stages two and three agree
            if (s2_reg == s3_reg)
                q <= s3_reg;
        end
    end
endmodule // tpfm_sync3
`default_nettype wire

/* bench/tpfm_pin_mux_monitor.sv */
// Purpose: port checker for the pin function mux
// Assumes: serial variant, bound onto the mux
// Notes:   pin inputs pass four flops, so windows are loose
`timescale 1ns/1ps
`default_nettype none
module tpfm_pin_mux_monitor
#(
    parameter HAS_SERIAL = 1
)
(
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       LOW_SUPPLY,
    input wire logic       MAIN_ROLE,
    input wire logic       ADDR_STRAP_PIN_B_OE,
    input wire logic       BCLK_PIN_OE,
    input wire logic       FSYNC_PIN_OE,
    input wire logic       FRAME_START,
    input wire logic       SYNC_LOST,
    input wire logic [6:0] I2C_TARGET_ADDR,
    input wire logic       TX_FUNC_A_EN,
    input wire logic       TX_FUNC_A_DATA,
    input wire logic       TX_FUNC_B_EN,
    input wire logic       RX_FUNC_B_ALT_EN,
    input wire logic       RX_FUNC_A_EN,
    input wire logic       MIC_INPUT_A_EN,
    input wire logic       SERIAL_TX_PIN_A_O,
    input wire logic       SERIAL_TX_PIN_A_OE,
    input wire logic       SERIAL_TX_PIN_B_OE,
    input wire logic       SERIAL_RX_PIN_A_OE,
    input wire logic       SERIAL_RX_PIN_B_OE,
    input wire logic [4:0] GPIO_CFG_EN
);
    wire no_oe = !(ADDR_STRAP_PIN_B_OE | BCLK_PIN_OE | FSYNC_PIN_OE |
        SERIAL_TX_PIN_A_OE | SERIAL_TX_PIN_B_OE | SERIAL_RX_PIN_A_OE |
        SERIAL_RX_PIN_B_OE);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    property p_rel_hiz;
        $rose(ARST_N) |-> no_oe [*4];
    endproperty
    a_rel_hiz: assert property (p_rel_hiz)
        else $error("pin driven after reset");
    property p_low_hiz;
        LOW_SUPPLY [*8] |-> no_oe;
    endproperty
    a_low_hiz: assert property (p_low_hiz)
        else $error("pin driven in brownout");
    property p_lost_hiz;
        $rose(SYNC_LOST) |-> ##1 no_oe [*4];
    endproperty
    a_lost_hiz: assert property (p_lost_hiz)
        else $error("pin driven after sync loss");
    property p_bclk_in;
        MAIN_ROLE [*3] |-> !BCLK_PIN_OE;
    endproperty
    a_bclk_in: assert property (p_bclk_in)
        else $error("bit clock driven in main");
    property p_fsync_in;
        MAIN_ROLE [*3] |-> !FSYNC_PIN_OE;
    endproperty
    a_fsync_in: assert property (p_fsync_in)
        else $error("frame sync driven in main");
    property p_addr_base;
        I2C_TARGET_ADDR[6:2] == 5'h1a;
    endproperty
    a_addr_base: assert property (p_addr_base)
        else $error("address upper bits wrong");
    property p_tx_a_data;
        HAS_SERIAL && $past(TX_FUNC_A_EN) && SERIAL_TX_PIN_A_OE
            |-> SERIAL_TX_PIN_A_O == $past(TX_FUNC_A_DATA);
    endproperty
    a_tx_a_data: assert property (p_tx_a_data)
        else $error("tx a not serial data");
    property p_tx_a_hiz;
        !$past(TX_FUNC_A_EN) && !$past(GPIO_CFG_EN[1]) |-> !SERIAL_TX_PIN_A_OE;
    endproperty
    a_tx_a_hiz: assert property (p_tx_a_hiz)
        else $error("tx a driven unconfigured");
    property p_rx_a_in;
        $past(RX_FUNC_A_EN) || $past(MIC_INPUT_A_EN) |-> !SERIAL_RX_PIN_A_OE;
    endproperty
    a_rx_a_in: assert property (p_rx_a_in)
        else $error("rx a driven while receiving");
    property p_tx_b_alt;
        $past(RX_FUNC_B_ALT_EN) && !$past(TX_FUNC_B_EN) |-> !SERIAL_TX_PIN_B_OE;
    endproperty
    a_tx_b_alt: assert property (p_tx_b_alt)
        else $error("tx b driven while receiving");
    property p_frame_pulse;
        FRAME_START |=> !FRAME_START;
    endproperty
    a_frame_pulse: assert property (p_frame_pulse)
        else $error("frame start too long");
    c_lost: cover property ($rose(SYNC_LOST));
    c_frame: cover property (FRAME_START);
    c_tx_a: cover property (SERIAL_TX_PIN_A_OE && TX_FUNC_A_EN);
endmodule // tpfm_pin_mux_monitor
bind tpfm_pin_mux tpfm_pin_mux_monitor #(.HAS_SERIAL(HAS_SERIAL))
    tpfm_pin_mux_monitor_i (.*);
`default_nettype wire

/* bench/tpfm_host_model.sv */
// Purpose: host model making frame sync and bit clock
// Assumes: host steps on core clock edges
// Notes:   both clocks stand still while run is low
`timescale 1ns/1ps
`default_nettype none
module tpfm_host_model
#(
    parameter int HALF = 128
)
(
    input  wire logic clk,
    input  wire logic run,
    output var logic  fsync,
    output var logic  bclk
);
    int cnt = 0;
    initial fsync = 1'b0;
    initial bclk = 1'b0;
    always @(posedge clk)
    begin
        if (run)
        begin
            bclk <= ~bclk;
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
                fsync <= ~fsync;
        end
    end
endmodule // tpfm_host_model
`default_nettype wire

/* bench/test_transceiver_pin_function_mux.sv */
// Purpose: self-checking bench for the pin function mux
// Assumes: main role by default, frame period 256 cycles
// Notes:   sync-loss count cut to 600 cycles for run time
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_pin_function_mux;
    localparam int LOSS = 600;
    logic CLK = 1'b0, ARST_N = 1'b0, LOW_SUPPLY = 1'b0, MAIN_ROLE = 1'b1;
    logic ADDR_STRAP_PIN_A_I = 1'b0, AUX_CLOCK_OUT_B_EN = 1'b0;
    logic BCLK_OUT_VAL = 1'b0, BCLK_AS_MIC_CLOCK = 1'b0, FSYNC_OUT_VAL = 1'b0;
    logic TX_FUNC_A_EN = 1'b0, TX_FUNC_A_DATA = 1'b0, TX_FUNC_B_EN = 1'b0;
    logic TX_FUNC_B_DATA = 1'b0, RX_FUNC_B_ALT_EN = 1'b0, RX_FUNC_A_EN = 1'b0;
    logic MIC_INPUT_A_EN = 1'b0, host_run = 1'b1;
    logic [7:0] AUX_CLOCK_DIV = 8'h03;
    logic [4:0] GPIO_CFG_EN = 5'h00, GPIO_DIR_OUT = 5'h00;
    logic [4:0] GPIO_OUT_VAL = 5'h00, pin_drv = 5'h00;
    int err_total = 0, checks_done = 0;
    wire host_fsync, host_bclk, MIC_CLOCK_OUT, FRAME_START, SYNC_LOST;
    wire RX_FUNC_A_DATA, RX_FUNC_B_DATA, MIC_INPUT_A_DATA;
    wire ADDR_STRAP_PIN_B_I, ADDR_STRAP_PIN_B_O, ADDR_STRAP_PIN_B_OE;
    wire BCLK_PIN_I, BCLK_PIN_O, BCLK_PIN_OE, FSYNC_PIN_I, FSYNC_PIN_O;
    wire FSYNC_PIN_OE, SERIAL_TX_PIN_A_I, SERIAL_TX_PIN_A_O;
    wire SERIAL_TX_PIN_A_OE, SERIAL_TX_PIN_B_I, SERIAL_TX_PIN_B_O;
    wire SERIAL_TX_PIN_B_OE, SERIAL_RX_PIN_A_I, SERIAL_RX_PIN_A_O;
    wire SERIAL_RX_PIN_A_OE, SERIAL_RX_PIN_B_I, SERIAL_RX_PIN_B_O;
    wire SERIAL_RX_PIN_B_OE;
    wire [6:0] I2C_TARGET_ADDR;
    wire [4:0] GPIO_IN_VAL;
    // wire level: design wins where it drives, else host or strap
    wire [6:0] oe_v = {SERIAL_RX_PIN_B_OE, SERIAL_RX_PIN_A_OE,
        SERIAL_TX_PIN_B_OE, SERIAL_TX_PIN_A_OE, ADDR_STRAP_PIN_B_OE,
        BCLK_PIN_OE, FSYNC_PIN_OE};
    wire [6:0] o_v = {SERIAL_RX_PIN_B_O, SERIAL_RX_PIN_A_O,
        SERIAL_TX_PIN_B_O, SERIAL_TX_PIN_A_O, ADDR_STRAP_PIN_B_O,
        BCLK_PIN_O, FSYNC_PIN_O};
    wire any_oe = |oe_v;
    assign {SERIAL_RX_PIN_B_I, SERIAL_RX_PIN_A_I, SERIAL_TX_PIN_B_I,
        SERIAL_TX_PIN_A_I, ADDR_STRAP_PIN_B_I, BCLK_PIN_I, FSYNC_PIN_I} =
        (oe_v & o_v) | (~oe_v & {pin_drv, host_bclk, host_fsync});
    tpfm_pin_mux #(.HAS_SERIAL(1), .SYNC_LOSS_CYC(LOSS)) tpfm_pin_mux_i (.*);
    tpfm_host_model #(.HALF(128)) tpfm_host_model_i (.clk(CLK),
        .run(host_run), .fsync(host_fsync), .bclk(host_bclk));
    always #25 CLK = ~CLK;
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #5;
    endtask
    task automatic do_reset(input logic a, input logic b);
        ARST_N = 1'b0;
        ADDR_STRAP_PIN_A_I = a;
        pin_drv[0] = b;
        cyc(6);
        chk(any_oe === 1'b0, "pin driven in reset");
        ARST_N = 1'b1;
        cyc(12);
        chk(I2C_TARGET_ADDR === {5'h1a, b, a}, "strap address");
    endtask
    task automatic wait_tx_a;
        int n;
        n = 0;
        while (SERIAL_TX_PIN_A_OE !== 1'b1 && n < 800)
        begin
            cyc(1);
            n++;
        end
        chk(n < 800, "pins not back");
        if (n == 800)
            summarize();
    endtask
    task automatic t_aux;
        int n;
        logic p;
        n = 0;
        chk(ADDR_STRAP_PIN_B_OE === 1'b0, "strap b not idle");
        GPIO_CFG_EN = 5'h01;
        GPIO_DIR_OUT = 5'h01;
        cyc(2);
        chk({ADDR_STRAP_PIN_B_OE, ADDR_STRAP_PIN_B_O} === 2'b10, "gpio b");
        AUX_CLOCK_OUT_B_EN = 1'b1;
        cyc(8);
        repeat (64)
        begin
            p = ADDR_STRAP_PIN_B_O;
            cyc(1);
            n += ADDR_STRAP_PIN_B_OE & ADDR_STRAP_PIN_B_O & ~p;
        end
        chk(n == 8, "aux clock rate");
        AUX_CLOCK_OUT_B_EN = 1'b0;
    endtask
    task automatic t_tx_a;
        GPIO_CFG_EN = 5'h02;
        GPIO_DIR_OUT = 5'h02;
        GPIO_OUT_VAL = 5'h02;
        cyc(2);
        chk({SERIAL_TX_PIN_A_OE, SERIAL_TX_PIN_A_O} === 2'b11, "gpio a");
        TX_FUNC_A_EN = 1'b1;
        cyc(2);
        chk({SERIAL_TX_PIN_A_OE, SERIAL_TX_PIN_A_O} === 2'b10, "tx a");
        TX_FUNC_A_EN = 1'b0;
        GPIO_DIR_OUT = 5'h00;
        pin_drv[1] = 1'b1;
        cyc(8);
        chk(GPIO_IN_VAL[1] === 1'b1, "gpio a in");
    endtask
    task automatic t_tx_b;
        GPIO_CFG_EN = 5'h04;
        GPIO_DIR_OUT = 5'h04;
        GPIO_OUT_VAL = 5'h04;
        RX_FUNC_B_ALT_EN = 1'b1;
        pin_drv[2] = 1'b1;
        cyc(8);
        chk(RX_FUNC_B_DATA === 1'b1, "alt rx on tx b");
        TX_FUNC_B_EN = 1'b1;
        cyc(2);
        chk({SERIAL_TX_PIN_B_OE, SERIAL_TX_PIN_B_O} === 2'b10, "tx b");
        TX_FUNC_B_EN = 1'b0;
        RX_FUNC_B_ALT_EN = 1'b0;
        cyc(2);
        chk({SERIAL_TX_PIN_B_OE, SERIAL_TX_PIN_B_O} === 2'b11, "gpio b");
    endtask
    task automatic t_rx_a;
        GPIO_CFG_EN = 5'h08;
        GPIO_DIR_OUT = 5'h08;
        GPIO_OUT_VAL = 5'h00;
        pin_drv[3] = 1'b1;
        cyc(2);
        chk({SERIAL_RX_PIN_A_OE, SERIAL_RX_PIN_A_O} === 2'b10, "gpio rx");
        RX_FUNC_A_EN = 1'b1;
        cyc(8);
        chk(RX_FUNC_A_DATA === 1'b1, "serial rx a");
        RX_FUNC_A_EN = 1'b0;
        MIC_INPUT_A_EN = 1'b1;
        cyc(16);
        chk(MIC_INPUT_A_DATA === 1'b1, "mic rx a");
        MIC_INPUT_A_EN = 1'b0;
    endtask
    task automatic t_roles;
        int m;
        int b;
        int k;
        logic p;
        logic q;
        m = 0;
        b = 0;
        k = 0;
        chk((BCLK_PIN_OE | FSYNC_PIN_OE) === 1'b0, "main drives");
        MAIN_ROLE = 1'b0;
        BCLK_OUT_VAL = 1'b1;
        FSYNC_OUT_VAL = 1'b1;
        cyc(4);
        chk({BCLK_PIN_OE, BCLK_PIN_O, FSYNC_PIN_OE, FSYNC_PIN_O} === 4'hf,
            "sub pins");
        BCLK_AS_MIC_CLOCK = 1'b1;
        cyc(4);
        repeat (64)
        begin
            // own frame sync must toggle or the mic clock stands still
            FSYNC_OUT_VAL = k[3];
            k++;
            p = BCLK_PIN_O;
            q = MIC_CLOCK_OUT;
            cyc(1);
            b += BCLK_PIN_O & ~p;
            m += MIC_CLOCK_OUT & ~q;
        end
        chk(b == m && m > 4, "bit clock as mic");
        BCLK_AS_MIC_CLOCK = 1'b0;
        MAIN_ROLE = 1'b1;
    endtask
    task automatic t_clocks;
        int m;
        int f;
        logic p;
        m = 0;
        f = 0;
        // two host frames first, so the measured period is a whole frame
        cyc(600);
        repeat (512)
        begin
            p = MIC_CLOCK_OUT;
            cyc(1);
            m += MIC_CLOCK_OUT & ~p;
            f += FRAME_START;
        end
        chk(m inside {[126:130]}, "mic clock rate");
        chk(f == 2, "frame starts");
    endtask
    task automatic t_loss;
        int n;
        n = 0;
        GPIO_CFG_EN = 5'h02;
        GPIO_DIR_OUT = 5'h02;
        cyc(2);
        host_run = 1'b0;
        while (SYNC_LOST !== 1'b1 && n < 800)
        begin
            cyc(1);
            n++;
        end
        chk(n >= LOSS - 260 && n < LOSS + 20, "sync loss delay");
        if (n == 800)
            summarize();
        cyc(1);
        chk(any_oe === 1'b0, "pin driven after loss");
        host_run = 1'b1;
        wait_tx_a();
        LOW_SUPPLY = 1'b1;
        cyc(8);
        chk(any_oe === 1'b0, "pin driven in brownout");
        LOW_SUPPLY = 1'b0;
        wait_tx_a();
    endtask
    initial
    begin
        for (int i = 0; i < 4; i++)
            do_reset(i[0], i[1]);
        t_aux();
        t_tx_a();
        t_tx_b();
        t_rx_a();
        t_roles();
        t_clocks();
        t_loss();
        summarize();
    end
endmodule // test_transceiver_pin_function_mux
`default_nettype wire
